// >>> src/frg_defines.svh
// register offsets, field positions, reset values and timing for the follow ratio gearing block
`ifndef FRG_DEFINES_SVH
`define FRG_DEFINES_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FRG_OFF_CTRL 8'h00
`define FRG_OFF_NUMER 8'h04
`define FRG_OFF_DENOM 8'h08
`define FRG_OFF_REMAIN 8'h0C
`define FRG_OFF_SPEED 8'h10
`define FRG_OFF_ACCEL 8'h14
`define FRG_OFF_ORIGIN 8'h18
`define FRG_OFF_EXTCNT 8'h1C
`define FRG_OFF_STATUS 8'h20
// ----------------------------------------------------------------
// control register command bits (write one to act)
// ----------------------------------------------------------------
`define FRG_CTRL_START 0
`define FRG_CTRL_ENC_RATIO 1
`define FRG_CTRL_PULSE_RATIO 2
`define FRG_CTRL_CNT_RESET 3
// ----------------------------------------------------------------
// reset values and scaling
// ----------------------------------------------------------------
`define FRG_NUMER_RST 16'h0001
`define FRG_DENOM_RST 16'h0001
`define FRG_SCALE_SHIFT 16
`define FRG_HSIZE_WORD 3'h2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FRG_CLK_HZ 100000000
`define FRG_SAMPLE_HZ 4000
`endif

// >>> src/frg_pkg.sv
// types shared by the follow ratio gearing block
package frg_pkg;
  // following mode
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_COUNT,
    MODE_ENC_RATIO,
    MODE_PULSE_RATIO
  } frg_mode_e;
  // whole state of the gearing top
  typedef struct packed {
    frg_mode_e mode;
    logic signed [15:0] ratioNumerator;
    logic signed [15:0] ratioDenominator;
    logic signed [15:0] actNum;
    logic signed [15:0] actDen;
    logic signed [31:0] remain;
    logic signed [31:0] speed;
    logic [31:0] accel;
    logic offsetOn;
    logic signed [31:0] ratioRem;
    logic signed [31:0] posCmd;
    logic signed [31:0] extCount;
    logic signed [15:0] extDelta;
    logic [31:0] tickCnt;
    logic tick;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] pinFlt;
    logic aValid;
    logic aWrite;
    logic [7:0] aAddr;
    logic [31:0] rdData;
    logic readyOut;
    logic respOut;
  } frg_state_s;
endpackage

// >>> src/frg_gearing.sv
// follow ratio gearing: scaled encoder or step following with phase offset, AHB-Lite registers
// Notes on behaviour
// - input change scaled by numerator over denominator
// - numerator is signed 16-bit, host set
// - denominator is signed 16-bit, host set
// - followed input: quadrature or step/direction
// - encoder ratio command selects and starts calculation
// - pulse ratio command follows step pulses
// - writing zero to origin zeroes position
// - counter mode command clears external counter
// - start applies newly programmed ratio
// - start in ratio mode begins nonzero offset
// - offset rate in 1/65536 counts per sample
// - remaining offset shrinks to zero, then stops
// - speed kept, acceleration overwritten by offset
// - writes act at once; zero speed pauses
// - remaining offset readback, zero when done
// - offset only in ratio follow modes
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`include "frg_defines.svh"
module frg_gearing
  import frg_pkg::*;
#(
  parameter int TICK_CYCLES = `FRG_CLK_HZ / `FRG_SAMPLE_HZ
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic encA,
  input wire logic encB,
  input wire logic stepIn,
  input wire logic dirIn,
  output logic [31:0] cmdPosition,
  output logic offsetBusy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1); // last count of one servo sample
  frg_state_s st; // registered state
  frg_state_s next_st; // next state
  logic wrPhase; // data phase of an accepted write
  logic signed [31:0] ratioAcc; // remainder plus scaled delta
  logic signed [31:0] ratioQuot; // whole counts of this sample
  logic [32:0] offSum; // fraction plus speed magnitude
  logic [31:0] offWhole; // whole counts ready to apply
  logic [31:0] remMag; // magnitude of remaining offset
  logic [31:0] offStep; // counts applied this sample
  logic signed [31:0] sampleMove; // total position change this sample
  logic signed [15:0] cycleDelta; // input count change this cycle
  logic [3:0] agree; // stages two and three agree
  logic oldA; // previous filtered encoder A
  logic oldB; // previous filtered encoder B
  logic newA; // new filtered encoder A
  logic newB; // new filtered encoder B
  logic stepRise; // filtered step rising edge
  logic ratioMode; // one of the two follow modes

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // pins, sample tick, follow arithmetic and the register bus
  always_comb begin
    // start from the held state so untouched fields keep their value
    next_st = st;
    ratioAcc = 32'sh0;
    ratioQuot = 32'sh0;
    offSum = 33'h0;
    offWhole = 32'h0;
    remMag = 32'h0;
    offStep = 32'h0;
    sampleMove = 32'sh0;
    cycleDelta = 16'sh0;
    // follow and offset run only in the two ratio modes
    ratioMode = (st.mode == MODE_ENC_RATIO) || (st.mode == MODE_PULSE_RATIO);

    // three stage pin synchroniser, a bit changes once stages two and three agree
    next_st.sync1 = {encA, encB, stepIn, dirIn};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    agree = ~(st.sync2 ^ st.sync3);
    next_st.pinFlt = (st.sync3 & agree) | (st.pinFlt & ~agree);

    // input decode, quadrature in all modes but step following
    oldA = st.pinFlt[3];
    oldB = st.pinFlt[2];
    newA = next_st.pinFlt[3];
    newB = next_st.pinFlt[2];
    stepRise = next_st.pinFlt[1] & ~st.pinFlt[1];
    if (st.mode == MODE_PULSE_RATIO) begin
      if (stepRise) begin
        cycleDelta = next_st.pinFlt[0] ? 16'sh0001 : -16'sh0001;
      end
    end else if (((oldA ^ newA) ^ (oldB ^ newB)) == 1'b1) begin
      cycleDelta = (oldA ^ newB) ? 16'sh0001 : -16'sh0001;
    end
    // the external count tracks the followed input in every mode
    next_st.extCount = st.extCount + 32'(cycleDelta);

    // servo sample tick
    next_st.tick = 1'b0;
    if (st.tickCnt >= TICK_LAST) begin
      next_st.tickCnt = 32'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tickCnt = st.tickCnt + 32'h1;
    end

    // input change gathered between samples
    if (st.tick) begin
      next_st.extDelta = cycleDelta;
    end else begin
      next_st.extDelta = st.extDelta + cycleDelta;
    end

    // one servo sample of following and offset
    if (st.tick && ratioMode) begin
      // scaled follow, remainder kept for the next sample
      // a zero denominator stops following instead of dividing by zero
      if (st.actDen != 16'sh0) begin
        ratioAcc = st.ratioRem + 32'(st.extDelta) * 32'(st.actNum);
        ratioQuot = ratioAcc / 32'(st.actDen);
        next_st.ratioRem = ratioAcc - 32'(ratioQuot * 32'(st.actDen));
      end
      sampleMove = ratioQuot;
      // phase offset, speed in 1/65536 counts per sample
      if (st.offsetOn && st.speed != 32'sh0) begin
        offSum = {17'h0, st.accel[15:0]} + {1'b0, (st.speed < 0) ? -st.speed : st.speed};
        offWhole = {15'h0, offSum[32:`FRG_SCALE_SHIFT]};
        remMag = (st.remain < 0) ? 32'(-st.remain) : 32'(st.remain);
        // never step past zero
        offStep = (offWhole > remMag) ? remMag : offWhole;
        next_st.accel = {15'h0, offWhole[0], offSum[15:0]};
        // move the remaining offset toward zero and the shaft by the same counts
        if (st.remain < 0) begin
          next_st.remain = st.remain + $signed(offStep);
          sampleMove = sampleMove - $signed(offStep);
        end else begin
          next_st.remain = st.remain - $signed(offStep);
          sampleMove = sampleMove + $signed(offStep);
        end
      end
      next_st.posCmd = st.posCmd + sampleMove;
    end

    // bus data phase: writes take effect at once
    wrPhase = st.aValid && st.aWrite;
    // several command bits in one write act in the order below
    if (wrPhase) begin
      unique case (st.aAddr)
        `FRG_OFF_CTRL: begin
          if (hwdata[`FRG_CTRL_CNT_RESET]) begin
            next_st.mode = MODE_COUNT;
            next_st.extCount = 32'sh0;
            next_st.extDelta = 16'sh0;
          end
          if (hwdata[`FRG_CTRL_ENC_RATIO]) begin
            next_st.mode = MODE_ENC_RATIO;
            next_st.actNum = st.ratioNumerator;
            next_st.actDen = st.ratioDenominator;
            next_st.ratioRem = 32'sh0;
          end
          if (hwdata[`FRG_CTRL_PULSE_RATIO]) begin
            next_st.mode = MODE_PULSE_RATIO;
            next_st.actNum = st.ratioNumerator;
            next_st.actDen = st.ratioDenominator;
            next_st.ratioRem = 32'sh0;
          end
          if (hwdata[`FRG_CTRL_START]) begin
            next_st.actNum = st.ratioNumerator;
            next_st.actDen = st.ratioDenominator;
            next_st.ratioRem = 32'sh0;
            // an offset only starts when counts remain after this sample
            if (ratioMode && next_st.remain != 32'sh0) begin
              next_st.offsetOn = 1'b1;
              next_st.accel = 32'h0;
            end
          end
        end
        `FRG_OFF_NUMER: next_st.ratioNumerator = hwdata[15:0];
        `FRG_OFF_DENOM: next_st.ratioDenominator = hwdata[15:0];
        `FRG_OFF_REMAIN: begin
          next_st.remain = hwdata;
          if (hwdata == 32'h0) begin
            next_st.offsetOn = 1'b0;
          end
        end
        `FRG_OFF_SPEED: next_st.speed = hwdata;
        `FRG_OFF_ACCEL: next_st.accel = hwdata;
        `FRG_OFF_ORIGIN: begin
          if (hwdata == 32'h0) begin
            next_st.posCmd = 32'sh0;
          end
        end
        default: begin
          // read only or unmapped: ignored
        end
      endcase
    end

    // offset ends when nothing remains or follow mode is left, after any write
    if ((next_st.mode != MODE_ENC_RATIO && next_st.mode != MODE_PULSE_RATIO) || next_st.remain == 32'sh0) begin
      next_st.offsetOn = 1'b0;
    end

    // bus address phase: capture request, prepare read data
    next_st.aValid = hsel && htrans[1] && hready && (hsize == `FRG_HSIZE_WORD);
    // direction and address kept for the data phase
    next_st.aWrite = hwrite;
    next_st.aAddr = haddr[7:0];
    next_st.rdData = 32'h0;
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[7:0])
        `FRG_OFF_CTRL: next_st.rdData = {30'h0, st.mode};
        `FRG_OFF_NUMER: next_st.rdData = 32'(st.ratioNumerator);
        `FRG_OFF_DENOM: next_st.rdData = 32'(st.ratioDenominator);
        `FRG_OFF_REMAIN: next_st.rdData = st.remain;
        `FRG_OFF_SPEED: next_st.rdData = st.speed;
        `FRG_OFF_ACCEL: next_st.rdData = st.accel;
        `FRG_OFF_ORIGIN: next_st.rdData = st.posCmd;
        `FRG_OFF_EXTCNT: next_st.rdData = st.extCount;
        `FRG_OFF_STATUS: next_st.rdData = {29'h0, ratioMode, st.offsetOn, st.tick};
        default: next_st.rdData = 32'h0;
      endcase
    end
    // no wait states and always an OKAY answer
    next_st.readyOut = 1'b1;
    next_st.respOut = 1'b0;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // one register stage for the whole state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
      st.mode <= MODE_IDLE;
      // ratio starts at one to one so a bare mode command follows directly
      st.ratioNumerator <= `FRG_NUMER_RST;
      st.ratioDenominator <= `FRG_DENOM_RST;
      st.actNum <= `FRG_NUMER_RST;
      st.actDen <= `FRG_DENOM_RST;
      st.readyOut <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign hreadyout = st.readyOut;
  assign hrdata = st.rdData;
  assign hresp = st.respOut;
  assign cmdPosition = st.posCmd;
  assign offsetBusy = st.offsetOn;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  logic wrCtrl; // data phase write to the control register
  assign wrCtrl = st.aValid && st.aWrite && st.aAddr == `FRG_OFF_CTRL;

  // position is cleared by an origin write of zero
  origin_zero_a: assert property (
    (st.aValid && st.aWrite && st.aAddr == `FRG_OFF_ORIGIN && hwdata == 32'h0) |=> (cmdPosition == 32'h0))
    else $error("origin write of zero did not clear position");
  // counter mode clears the count and leaves follow
  counter_clear_a: assert property (
    (wrCtrl && hwdata[`FRG_CTRL_CNT_RESET] && !hwdata[1] && !hwdata[2])
      |=> (st.extCount == 32'sh0 && st.mode == MODE_COUNT))
    else $error("counter mode did not clear external count");
  // encoder ratio command loads the programmed numerator
  enc_select_a: assert property (
    (wrCtrl && hwdata[`FRG_CTRL_ENC_RATIO] && !hwdata[2])
      |=> (st.mode == MODE_ENC_RATIO && st.actNum == $past(st.ratioNumerator)))
    else $error("encoder ratio command not taken");
  // offset never runs outside the follow modes
  offset_mode_a: assert property (
    st.offsetOn |-> (st.mode == MODE_ENC_RATIO || st.mode == MODE_PULSE_RATIO))
    else $error("offset active outside follow modes");
  // start with counts remaining begins the offset
  offset_begin_a: assert property (
    (wrCtrl && hwdata[`FRG_CTRL_START] && hwdata[3:1] == 3'h0 && st.offsetOn == 1'b0
      && (st.mode == MODE_ENC_RATIO || st.mode == MODE_PULSE_RATIO) && st.remain != 32'sh0) |=> st.offsetOn)
    else $error("start did not begin phase offset");
  // offset stops as soon as nothing remains
  offset_done_a: assert property (
    (st.offsetOn && next_st.remain == 32'sh0) |=> !st.offsetOn)
    else $error("offset still active with nothing left");
  // each sample only shrinks the remaining offset
  offset_shrink_a: assert property (
    (st.tick && st.offsetOn && !(st.aValid && st.aWrite)) |=>
      ((st.remain < 0 ? -st.remain : st.remain) <= ($past(st.remain) < 0 ? -$past(st.remain) : $past(st.remain))))
    else $error("remaining offset grew during a sample");
  // zero speed holds the remaining offset
  pause_hold_a: assert property (
    (st.speed == 32'sh0 && !(st.aValid && st.aWrite)) |=> $stable(st.remain))
    else $error("offset moved with zero speed");
  // offset speed changes only by a write
  speed_kept_a: assert property (
    !(st.aValid && st.aWrite && st.aAddr == `FRG_OFF_SPEED) |=> $stable(st.speed))
    else $error("offset speed changed without a write");
  // active ratio changes only on a command
  ratio_hold_a: assert property (
    !wrCtrl |=> $stable(st.actNum) && $stable(st.actDen))
    else $error("active ratio changed without a command");

  // position moves only at a sample or an origin write
  pos_hold_a: assert property (
    (!st.tick && !(wrPhase && st.aAddr == `FRG_OFF_ORIGIN)) |=> $stable(st.posCmd))
    else $error("position moved outside a servo sample");

  // outside the ratio modes the position is not followed
  follow_idle_a: assert property (
    (!ratioMode && !(wrPhase && st.aAddr == `FRG_OFF_ORIGIN)) |=> $stable(st.posCmd))
    else $error("position followed outside ratio modes");

  // the external count moves by at most one count per cycle
  count_step_a: assert property (
    !wrCtrl |=> (st.extCount == $past(st.extCount) || st.extCount == $past(st.extCount) + 32'sh1
      || st.extCount == $past(st.extCount) - 32'sh1))
    else $error("external count jumped");

  // remaining offset readback shows the value at the address phase
  remain_read_a: assert property (
    (st.aValid && !st.aWrite && st.aAddr == `FRG_OFF_REMAIN) |-> (hrdata == $past(st.remain)))
    else $error("remaining offset readback wrong");

  // the carried remainder stays below one denominator
  rem_bound_a: assert property (
    (st.actDen != 16'sh0) |-> ((st.ratioRem < 0 ? -st.ratioRem : st.ratioRem)
      < (st.actDen < 0 ? -32'(st.actDen) : 32'(st.actDen))))
    else $error("ratio remainder out of range");

  // the slave never stalls and never reports an error
  bus_okay_a: assert property (
    hreadyout && !hresp)
    else $error("bus answered with a wait or an error");
endmodule

// >>> sim/frg_enc_src.sv
// quadrature and step/direction source that drives the follow pins
module frg_enc_src (
  input wire logic mclk,
  output logic encA,
  output logic encB,
  output logic stepIn,
  output logic dirIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins idle low at time zero
  initial begin
    {encA, encB, stepIn, dirIn} = 4'h0;
  end
  // quadrature steps, up order 00,01,11,10; each level held for hold cycles
  task automatic quad(input int n, input int hold);
    logic [1:0] s;
    s = {encA, encB};
    repeat (n < 0 ? -n : n) begin
      case (s)
        2'b00: s = n > 0 ? 2'b01 : 2'b10;
        2'b01: s = n > 0 ? 2'b11 : 2'b00;
        2'b11: s = n > 0 ? 2'b10 : 2'b01;
        default: s = n > 0 ? 2'b00 : 2'b11;
      endcase
      encA <= s[1];
      encB <= s[0];
      repeat (hold) @(posedge mclk);
    end
  endtask
  // step pulses, direction set with the first step and held through the burst
  task automatic step(input int n, input int hold);
    dirIn <= n > 0;
    repeat (n < 0 ? -n : n) begin
      stepIn <= 1'b1;
      repeat (hold) @(posedge mclk);
      stepIn <= 1'b0;
      repeat (hold) @(posedge mclk);
    end
  endtask
endmodule

// >>> sim/frg_gearing_tb.sv
// self-checking bench for the follow ratio gearing block with a behavioural position model
`include "frg_defines.svh"
module frg_gearing_tb
  import frg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 40; // short servo sample
  localparam int SPD = 32'h0014_8000; // 20.5 counts per sample
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, offsetBusy, encA, encB, stepIn, dirIn;
  logic [31:0] hrdata, cmdPosition, rd;
  logic [31:0] seed = 32'h8CC50105;
  int nFail = 0;
  int testsRun = 0;
  int expPos, n, c0;
  int numQ[$] = '{1, 41, -3, 5, 0};
  int denQ[$] = '{1, 8, 2, -3, 1};
  int cntQ[$] = '{12, -9, 7, -5, 6};
  int modeQ[$] = '{2, 2, 3, 3, 2};
  // free-running clock
  always #5 mclk = ~mclk;
  frg_gearing #(.TICK_CYCLES(TICK)) frg_gearing_i (.mclk(mclk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .encA(encA), .encB(encB), .stepIn(stepIn),
    .dirIn(dirIn), .cmdPosition(cmdPosition), .offsetBusy(offsetBusy));
  frg_enc_src frg_enc_src_i (.mclk(mclk), .encA(encA), .encB(encB), .stepIn(stepIn), .dirIn(dirIn));
  // xorshift stream for random register values
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // verdict and end of run
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // word compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one edge with hready high, bounded
  task automatic waitRdy();
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      nFail++;
      wrapUp();
    end
  endtask
  // single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // wait k servo samples
  task automatic samples(input int k);
    repeat (k * TICK) @(posedge mclk);
  endtask
  // drive the followed input of table entry i
  task automatic move(input int i, input int c);
    if (modeQ[i] == 3) begin
      frg_enc_src_i.step(c, i == 3 ? 12 : 4);
    end else begin
      frg_enc_src_i.quad(c, i == 1 ? 9 : 4);
    end
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    nFail++;
    wrapUp();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    sysRst <= 1'b0;
    chk("pos rst", 32'h0, cmdPosition);
    bus(0, `FRG_OFF_DENOM, 0);
    chk("denom rst", `FRG_DENOM_RST, rd);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      bus(1, `FRG_OFF_NUMER, seed);
      bus(0, `FRG_OFF_NUMER, 0);
      chk("numer", {{16{seed[15]}}, seed[15:0]}, rd);
      bus(1, `FRG_OFF_DENOM, ~seed);
      bus(0, `FRG_OFF_DENOM, 0);
      chk("denom", {{16{~seed[15]}}, ~seed[15:0]}, rd);
    end
    bus(1, 8'h24, 32'hFFFFFFFF);
    bus(0, 8'h24, 0);
    chk("unmapped", 32'h0, rd);
    // ratio table, last entry random
    for (int i = 0; i < 5; i++) begin
      if (i == 4) begin
        seed = xs(seed);
        numQ[4] = $signed(seed[6:0]);
        denQ[4] = int'(seed[11:8]) + 1;
      end
      bus(1, `FRG_OFF_REMAIN, 0);
      bus(1, `FRG_OFF_NUMER, numQ[i]);
      bus(1, `FRG_OFF_DENOM, denQ[i]);
      bus(1, `FRG_OFF_CTRL, modeQ[i] == 2 ? 32'h3 : 32'h5);
      bus(1, `FRG_OFF_ORIGIN, 0);
      bus(0, `FRG_OFF_CTRL, 0);
      chk("mode", modeQ[i], {30'h0, rd[1:0]});
      move(i, cntQ[i]);
      samples(4);
      expPos = cntQ[i] * numQ[i] / denQ[i];
      chk("follow", expPos, cmdPosition);
      bus(1, `FRG_OFF_NUMER, 100);
      move(i, cntQ[i] > 0 ? 2 : -2);
      samples(4);
      expPos = (cntQ[i] + (cntQ[i] > 0 ? 2 : -2)) * numQ[i] / denQ[i];
      chk("held ratio", expPos, cmdPosition);
    end
    // phase offset with pause and resume
    bus(1, `FRG_OFF_ORIGIN, 0);
    bus(1, `FRG_OFF_ACCEL, 32'h12345678);
    bus(1, `FRG_OFF_REMAIN, 300);
    bus(1, `FRG_OFF_SPEED, SPD);
    bus(1, `FRG_OFF_CTRL, 32'h1);
    samples(3);
    bus(1, `FRG_OFF_SPEED, 0);
    samples(1);
    bus(0, `FRG_OFF_REMAIN, 0);
    n = rd;
    chk("offset sum", 300, n + cmdPosition);
    chk("offset begun", 1, {31'h0, n > 200 && n < 300});
    samples(3);
    bus(0, `FRG_OFF_REMAIN, 0);
    chk("paused", n, rd);
    chk("busy", 1, {31'h0, offsetBusy});
    bus(0, `FRG_OFF_STATUS, 0);
    chk("status", 32'h6, rd & 32'hFFFFFFFE);
    bus(1, `FRG_OFF_SPEED, SPD);
    c0 = 0;
    while (offsetBusy === 1'b1 && c0 < 2000) begin
      @(posedge mclk);
      c0++;
    end
    chk("rate", 1, {31'h0, c0 >= ((n * 65536 - 65535) / SPD - 1) * TICK
      && c0 <= (n * 65536 / SPD + 1) * TICK + 5});
    bus(0, `FRG_OFF_REMAIN, 0);
    chk("remain done", 0, rd);
    chk("offset pos", 300, cmdPosition);
    bus(0, `FRG_OFF_SPEED, 0);
    chk("speed kept", SPD, rd);
    bus(0, `FRG_OFF_ACCEL, 0);
    chk("accel used", 1, {31'h0, rd !== 32'h12345678});
    // counter mode: no offset, counter cleared
    bus(1, `FRG_OFF_CTRL, 32'h8);
    bus(0, `FRG_OFF_EXTCNT, 0);
    chk("cnt clear", 0, rd);
    bus(0, `FRG_OFF_CTRL, 0);
    chk("mode cnt", 1, {30'h0, rd[1:0]});
    bus(1, `FRG_OFF_REMAIN, 50);
    bus(1, `FRG_OFF_CTRL, 32'h1);
    frg_enc_src_i.quad(-10, 4);
    samples(3);
    chk("no offset", 0, {31'h0, offsetBusy});
    chk("pos kept", 300, cmdPosition);
    bus(0, `FRG_OFF_EXTCNT, 0);
    chk("ext count", -10, rd);
    bus(1, `FRG_OFF_ORIGIN, 5);
    bus(0, `FRG_OFF_ORIGIN, 0);
    chk("origin kept", 300, rd);
    bus(1, `FRG_OFF_ORIGIN, 0);
    bus(0, `FRG_OFF_ORIGIN, 0);
    chk("origin zero", 0, rd);
    wrapUp();
  end
endmodule
